//--- src/ptmr_defines.svh
// register offsets, field positions, reset values and divider counts of the periodic timer
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
`ifndef PTMR_DEFINES_SVH
`define PTMR_DEFINES_SVH

`define PTMR_OFF_CTRLA    8'h00
`define PTMR_OFF_CTRLB    8'h04
`define PTMR_OFF_CNTLO    8'h08
`define PTMR_OFF_CNTHI    8'h0C
`define PTMR_OFF_CMPALO   8'h10
`define PTMR_OFF_CMPAHI   8'h14
`define PTMR_OFF_PERLO    8'h18
`define PTMR_OFF_PERHI    8'h1C
`define PTMR_OFF_STATUS   8'h20

`define PTMR_CA_PAUSE     7
`define PTMR_CA_CKSEL_LSB 4
`define PTMR_CA_ON        3
`define PTMR_CB_MODE_LSB  6
`define PTMR_CB_PINF_LSB  4
`define PTMR_CB_OC        3
`define PTMR_CB_POL       2
`define PTMR_CB_CLRSEL    0
`define PTMR_ST_FLAGA     0
`define PTMR_ST_FLAGP     1

`define PTMR_RST_CTRLA    8'h00
`define PTMR_RST_CTRLB    8'h00
`define PTMR_RST_CMP      10'h000
`define PTMR_CA_IMPL_MASK 8'hF8

`define PTMR_SYSDIV_LAST  2'h3
`define PTMR_HDIV16_LAST  4'hF
`define PTMR_HDIV64_LAST  6'h3F

`define PTMR_RESP_OKAY    2'h0
`define PTMR_RESP_SLVERR  2'h2

`endif

//--- src/ptmr_pkg.sv
// types shared by the periodic timer
// assumes the defines header carries all numeric constants
package ptmr_pkg;

	typedef enum logic [1:0]
	{
		PTMR_MODE_CMP,
		PTMR_MODE_UNDEF,
		PTMR_MODE_PWM,
		PTMR_MODE_TMR
	} ptmr_mode_t;

	typedef enum logic [2:0]
	{
		PTMR_CK_SYS4,
		PTMR_CK_SYS,
		PTMR_CK_H16,
		PTMR_CK_H64,
		PTMR_CK_SUBA,
		PTMR_CK_SUBB,
		PTMR_CK_PINR,
		PTMR_CK_PINF
	} ptmr_cksel_t;

	typedef enum logic [1:0]
	{
		PTMR_PF_NONE,
		PTMR_PF_LOW,
		PTMR_PF_HIGH,
		PTMR_PF_TOGGLE
	} ptmr_pinf_t;

endpackage

//--- src/ptmr_periodic_timer.sv
// 10-bit periodic timer with compare, PWM, single pulse and timer/counter modes
// assumes an AXI4-Lite master on clock; pin and other clock inputs are asynchronous
`include "ptmr_defines.svh"

module ptmr_periodic_timer
	import ptmr_pkg::*;
	#(
	parameter int ADDR_W = 8
	)
	(
	input  wire logic              clock,
	input  wire logic              arst_n,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              extClockPin,
	input  wire logic              highClock,
	input  wire logic              subClock,
	output logic                   timerOutputPin,
	output logic                   timerOutputEn
	);

	function automatic logic regHit(input logic [7:0] addr, input logic [7:0] off);
		regHit = (addr[7:2] == off[7:2]);
	endfunction

	function automatic logic isMapped(input logic [7:0] addr);
		isMapped = (addr[7:2] <= 6'(`PTMR_OFF_STATUS >> 2));
	endfunction

	logic [7:0]  ctrlA;
	logic [7:0]  ctrlB;
	logic [9:0]  count;
	logic [9:0]  cmpA;
	logic [9:0]  period;
	logic        flagA;
	logic        flagP;
	logic        onPrev;
	logic        pinLevel;
	logic [2:0]  syncA;
	logic [2:0]  syncB;
	logic [2:0]  syncPrev;
	logic [1:0]  sysDiv;
	logic [5:0]  hDiv;
	logic        awHeld;
	logic [7:0]  awAddrQ;
	logic        wHeld;
	logic [31:0] wDataQ;
	logic [3:0]  wStrbQ;

	// control fields
	wire         pause      = ctrlA[`PTMR_CA_PAUSE];
	wire         counterOn  = ctrlA[`PTMR_CA_ON];
	ptmr_cksel_t clockSelect;
	ptmr_mode_t  modeField;
	ptmr_pinf_t  pinFunction;
	assign clockSelect = ptmr_cksel_t'(ctrlA[`PTMR_CA_CKSEL_LSB +: 3]);
	assign modeField   = ptmr_mode_t'(ctrlB[`PTMR_CB_MODE_LSB +: 2]);
	assign pinFunction = ptmr_pinf_t'(ctrlB[`PTMR_CB_PINF_LSB +: 2]);
	wire         outputControl  = ctrlB[`PTMR_CB_OC];
	wire         outputPolarity = ctrlB[`PTMR_CB_POL];
	wire         clearSelect    = ctrlB[`PTMR_CB_CLRSEL];

	// clock sources; only the second sync stage and later are looked at
	wire [2:0] pinRise = syncB & ~syncPrev;
	wire [2:0] pinFall = ~syncB & syncPrev;
	wire       extRise = pinRise[0];
	wire       extFall = pinFall[0];
	wire       hRise   = pinRise[1];
	wire       subRise = pinRise[2];
	wire       tickSys4 = (sysDiv == `PTMR_SYSDIV_LAST);
	wire       tickH16  = hRise && (hDiv[3:0] == `PTMR_HDIV16_LAST);
	wire       tickH64  = hRise && (hDiv == `PTMR_HDIV64_LAST);

	wire srcEdge =
		(clockSelect == PTMR_CK_SYS4) ? tickSys4 :
		(clockSelect == PTMR_CK_SYS)  ? 1'b1 :
		(clockSelect == PTMR_CK_H16)  ? tickH16 :
		(clockSelect == PTMR_CK_H64)  ? tickH64 :
		(clockSelect == PTMR_CK_PINR) ? extRise :
		(clockSelect == PTMR_CK_PINF) ? extFall :
		subRise;

	// counter core
	wire       onRise   = counterOn && !onPrev;
	wire       tick     = counterOn && !pause && srcEdge;
	wire [9:0] nextVal  = count + 10'h001;
	wire       matchA   = (nextVal == cmpA);
	wire       matchP   = (nextVal == period);
	wire       pwmMode  = (modeField == PTMR_MODE_PWM);
	wire       cmpMode  = (modeField == PTMR_MODE_CMP);
	wire       single   = pwmMode && (pinFunction == PTMR_PF_TOGGLE);
	// period zero makes nextVal==period only at wrap, which is the overflow clear
	wire       clearNow = single ? 1'b0 :
		pwmMode ? matchP :
		(clearSelect ? matchA : matchP);
	wire       evtA     = tick && matchA && (pwmMode || cmpA != `PTMR_RST_CMP);
	wire       evtP     = tick && matchP && !single && (pwmMode || !clearSelect);
	wire       pulseEnd = single && tick && matchA;
	wire       extArm   = (clockSelect == PTMR_CK_PINF) ? extFall : extRise;
	// a pin edge only arms while off, so a running pulse is never restarted
	wire       pulseArm = single && extArm && !counterOn;
	wire       pwmActive = (count < cmpA);

	// compare mode pin action; skipped when it asks for the initial level
	wire reqLevel  = (pinFunction == PTMR_PF_HIGH);
	wire cmpAct    = (pinFunction == PTMR_PF_LOW) || (pinFunction == PTMR_PF_HIGH);
	wire cmpLevel  =
		(pinFunction == PTMR_PF_TOGGLE) ? !pinLevel :
		(cmpAct && reqLevel != outputControl) ? reqLevel :
		pinLevel;
	wire pwmLevel  =
		(pinFunction == PTMR_PF_NONE) ? !outputControl :
		(pinFunction == PTMR_PF_LOW)  ? outputControl :
		(pinFunction == PTMR_PF_HIGH) ? (pwmActive ? outputControl : !outputControl) :
		(counterOn ? outputControl : !outputControl);
	wire next_pinLevel =
		onRise ? outputControl :
		(cmpMode && evtA) ? cmpLevel :
		pwmMode ? pwmLevel :
		pinLevel;

	// bus slave: address and data may arrive in either order
	assign awready = !awHeld && !bvalid;
	assign wready  = !wHeld && !bvalid;
	assign arready = !rvalid;
	wire        awTake  = awvalid && awready;
	wire        wTake   = wvalid && wready;
	wire        arTake  = arvalid && arready;
	wire        doWrite = (awHeld || awTake) && (wHeld || wTake) && !bvalid;
	wire [7:0]  wrAddr  = awHeld ? awAddrQ : awaddr[7:0];
	wire [31:0] wrData  = wHeld ? wDataQ : wdata;
	wire [3:0]  wrStrb  = wHeld ? wStrbQ : wstrb;
	wire        wrLane  = doWrite && wrStrb[0];
	wire [7:0]  wrByte  = wrData[7:0];
	wire        wrCtrlA = wrLane && regHit(wrAddr, `PTMR_OFF_CTRLA);
	wire        wrCtrlB = wrLane && regHit(wrAddr, `PTMR_OFF_CTRLB);
	wire        wrCmpAL = wrLane && regHit(wrAddr, `PTMR_OFF_CMPALO);
	wire        wrCmpAH = wrLane && regHit(wrAddr, `PTMR_OFF_CMPAHI);
	wire        wrPerL  = wrLane && regHit(wrAddr, `PTMR_OFF_PERLO);
	wire        wrPerH  = wrLane && regHit(wrAddr, `PTMR_OFF_PERHI);
	wire        wrStat  = wrLane && regHit(wrAddr, `PTMR_OFF_STATUS);

	// hardware sets and clears of the on bit override a simultaneous write
	wire [7:0] writtenA = wrCtrlA ? (wrByte & `PTMR_CA_IMPL_MASK) : ctrlA;
	wire       next_on  = pulseArm ? 1'b1 : (pulseEnd ? 1'b0 : writtenA[`PTMR_CA_ON]);
	wire [7:0] next_ctrlA = {writtenA[7:4], next_on, 3'h0};

	wire [9:0] next_count = onRise ? 10'h000 :
		tick ? (clearNow ? 10'h000 : nextVal) :
		count;

	wire [7:0] araddr8 = araddr[7:0];
	wire [7:0] rdByte  =
		regHit(araddr8, `PTMR_OFF_CTRLA)  ? ctrlA :
		regHit(araddr8, `PTMR_OFF_CTRLB)  ? ctrlB :
		regHit(araddr8, `PTMR_OFF_CNTLO)  ? count[7:0] :
		regHit(araddr8, `PTMR_OFF_CNTHI)  ? {6'h00, count[9:8]} :
		regHit(araddr8, `PTMR_OFF_CMPALO) ? cmpA[7:0] :
		regHit(araddr8, `PTMR_OFF_CMPAHI) ? {6'h00, cmpA[9:8]} :
		regHit(araddr8, `PTMR_OFF_PERLO)  ? period[7:0] :
		regHit(araddr8, `PTMR_OFF_PERHI)  ? {6'h00, period[9:8]} :
		regHit(araddr8, `PTMR_OFF_STATUS) ? {6'h00, flagP, flagA} :
		8'h00;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			syncA    <= 3'h0;
			syncB    <= 3'h0;
			syncPrev <= 3'h0;
		end
		else
		begin
			syncA    <= {subClock, highClock, extClockPin};
			syncB    <= syncA;
			syncPrev <= syncB;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sysDiv <= 2'h0;
			hDiv   <= 6'h00;
		end
		else
		begin
			sysDiv <= sysDiv + 2'h1;
			if (hRise)
				hDiv <= hDiv + 6'h01;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrlA    <= `PTMR_RST_CTRLA;
			ctrlB    <= `PTMR_RST_CTRLB;
			count    <= `PTMR_RST_CMP;
			onPrev   <= 1'b0;
			pinLevel <= 1'b0;
		end
		else
		begin
			ctrlA    <= next_ctrlA;
			if (wrCtrlB)
				ctrlB <= wrByte;
			count    <= next_count;
			onPrev   <= counterOn;
			pinLevel <= next_pinLevel;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cmpA   <= `PTMR_RST_CMP;
			period <= `PTMR_RST_CMP;
		end
		else
		begin
			if (wrCmpAL)
				cmpA[7:0] <= wrByte;
			if (wrCmpAH)
				cmpA[9:8] <= wrByte[1:0];
			if (wrPerL)
				period[7:0] <= wrByte;
			if (wrPerH)
				period[9:8] <= wrByte[1:0];
		end
	end

	// write-one-to-clear; a new match in the same cycle keeps the flag
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			flagA <= 1'b0;
			flagP <= 1'b0;
		end
		else
		begin
			flagA <= evtA || (flagA && !(wrStat && wrByte[`PTMR_ST_FLAGA]));
			flagP <= evtP || (flagP && !(wrStat && wrByte[`PTMR_ST_FLAGP]));
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			awHeld  <= 1'b0;
			awAddrQ <= 8'h00;
			wHeld   <= 1'b0;
			wDataQ  <= 32'h0000_0000;
			wStrbQ  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= `PTMR_RESP_OKAY;
		end
		else
		begin
			if (awTake && !doWrite)
			begin
				awHeld  <= 1'b1;
				awAddrQ <= awaddr[7:0];
			end
			if (wTake && !doWrite)
			begin
				wHeld  <= 1'b1;
				wDataQ <= wdata;
				wStrbQ <= wstrb;
			end
			if (doWrite)
			begin
				awHeld <= 1'b0;
				wHeld  <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= isMapped(wrAddr) ? `PTMR_RESP_OKAY : `PTMR_RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `PTMR_RESP_OKAY;
		end
		else if (arTake)
		begin
			rvalid <= 1'b1;
			rdata  <= {24'h000000, rdByte};
			rresp  <= isMapped(araddr8) ? `PTMR_RESP_OKAY : `PTMR_RESP_SLVERR;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end

	// pin released in timer/counter mode, so its level there means nothing
	assign timerOutputEn  = (modeField != PTMR_MODE_TMR);
	assign timerOutputPin = timerOutputEn && (pinLevel ^ outputPolarity);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	a_on_rise_clear: assert property (onRise |=> count == 10'h000)
		else $error("count not cleared after on rise");
	a_pause_hold: assert property (pause && !onRise |=> count == $past(count))
		else $error("count moved while paused");
	a_off_hold: assert property (!counterOn |=> $stable(count))
		else $error("count moved while off");
	a_count_step: assert property (tick && !clearNow && !onRise |=> count == $past(nextVal))
		else $error("count did not step by one");
	a_clear_on_a: assert property (tick && !pwmMode && clearSelect && matchA
		&& !onRise |=> count == 10'h000)
		else $error("count not cleared on A match");
	a_pwm_ignore_clr: assert property (tick && pwmMode && !single && matchP
		&& !onRise |=> count == 10'h000 && flagP)
		else $error("pwm period clear missing");
	a_init_level: assert property (onRise |=> pinLevel == $past(outputControl))
		else $error("pin not at initial level");
	a_cmp_same_lvl: assert property (cmpMode && !onRise && outputControl
		&& pinFunction == PTMR_PF_HIGH && $stable(ctrlB) |=> $stable(pinLevel))
		else $error("pin changed to its initial level");
	a_cmp_drive_hi: assert property (cmpMode && evtA && !onRise && !outputControl
		&& pinFunction == PTMR_PF_HIGH |=> pinLevel)
		else $error("pin not driven high on A match");
	a_tmr_release: assert property (modeField == PTMR_MODE_TMR
		|-> !timerOutputEn && !timerOutputPin)
		else $error("pin driven in timer mode");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");

	// clear, flag, PWM level, single pulse and read data checks
	a_cmp_clr_p: assert property (tick && !pwmMode && !clearSelect && matchP
		&& !onRise |=> count == 10'h000 && flagP)
		else $error("count not cleared on P match");
	a_flag_a_set: assert property (evtA |=> flagA)
		else $error("match A flag not set");
	a_pwm_active_lvl: assert property (pwmMode && pinFunction == PTMR_PF_LOW
		&& !onRise |=> pinLevel == $past(outputControl))
		else $error("pin not held at active level");
	a_pulse_stop: assert property (pulseEnd |=> !counterOn)
		else $error("single pulse did not stop");
	a_rdata_high: assert property (rvalid |-> rdata[31:8] == 24'h000000)
		else $error("unused read bits not zero");

	c_pwm_period: cover property (pwmMode && tick && matchP);
	c_pulse_end: cover property (pulseEnd ##1 !counterOn);
	c_pause_resume: cover property (counterOn && pause ##1 !pause [*2]);
	c_flag_race: cover property (evtA && wrStat && wrByte[`PTMR_ST_FLAGA]);
	c_pin_trigger: cover property (pulseArm);

endmodule

//--- testbench/ptmr_pin_model.sv
// far-side model: external clock source pin and the timer output pin
// assumes the timer's enable marks when it drives its output pin
module ptmr_pin_model
(
	input  wire logic clock,
	input  wire logic timerOutputPin,
	input  wire logic timerOutputEn,
	output logic      extClockPin,
	output logic      pinLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	// board pull-down holds the pin when the timer leaves it undriven
	assign pinLevel = timerOutputEn ? timerOutputPin : 1'b0;
	initial extClockPin = 1'b0;
	// pulses stay several clocks wide so the two-stage sync sees each edge
	task automatic pulse(input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clock) extClockPin <= 1'b1;
			repeat (4) @(posedge clock);
			extClockPin <= 1'b0;
			repeat (3) @(posedge clock);
		end
		repeat (6) @(posedge clock);
	endtask
endmodule

//--- testbench/ptmr_periodic_timer_tb_top.sv
// bench for the periodic timer: register access over AXI4-Lite plus pin checks
// assumes the pin model drives the external clock pin
`include "ptmr_defines.svh"

module ptmr_periodic_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock     = 1'b0;
	logic        arst_n    = 1'b0;
	logic        highClock = 1'b0;
	logic        subClock  = 1'b0;
	logic [7:0]  awaddr    = 8'h00;
	logic [7:0]  araddr    = 8'h00;
	logic [31:0] wdata     = 32'h0;
	logic [3:0]  wstrb     = 4'h0;
	logic        awvalid   = 1'b0;
	logic        wvalid    = 1'b0;
	logic        bready    = 1'b0;
	logic        arvalid   = 1'b0;
	logic        rready    = 1'b0;
	logic [3:0]  hDiv      = 4'h0;
	logic [3:0]  sDiv      = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        timerOutputPin, timerOutputEn, extClockPin, pinLevel;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, v, w, n;
	int          err_total = 0;
	int          compares  = 0;
	// cycles of the system clock per count step, for selects 000..101
	localparam int CPC [6] = '{4, 1, 96, 384, 10, 10};
	localparam logic [9:0] PT [10] = '{10'h000, 10'h040, 10'h081, 10'h062, 10'h0B0,
		10'h053, 10'h0C1, 10'h203, 10'h220, 10'h270};
	localparam logic [7:0] DCB [5] = '{8'hA8, 8'hA8, 8'hAC, 8'hA8, 8'hA0};
	localparam int DA [5] = '{2, 1, 1, 5, 1};
	localparam int DH [5] = '{20, 10, 30, 40, 30};
	localparam logic [7:0] SCB [3] = '{8'hC0, 8'hC1, 8'hA1};
	localparam int SA [3] = '{0, 6, 2};
	localparam int SP [3] = '{5, 0, 9};
	localparam int SLO [3] = '{2, 3, 3};
	localparam int SHI [3] = '{4, 5, 8};
	localparam int SFL [3] = '{2, 1, 3};

	ptmr_periodic_timer #(.ADDR_W(8)) u_ptmr_periodic_timer
	(
		.clock(clock), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.extClockPin(extClockPin), .highClock(highClock), .subClock(subClock),
		.timerOutputPin(timerOutputPin), .timerOutputEn(timerOutputEn)
	);
	ptmr_pin_model u_ptmr_pin_model
	(
		.clock(clock), .timerOutputPin(timerOutputPin), .timerOutputEn(timerOutputEn),
		.extClockPin(extClockPin), .pinLevel(pinLevel)
	);

	initial
	begin
		forever #4 clock = ~clock;
	end
	// slow clocks: high clock period 6 cycles, sub clock period 10 cycles
	always @(posedge clock)
	begin
		hDiv <= (hDiv == 4'h2) ? 4'h0 : hDiv + 4'h1;
		sDiv <= (sDiv == 4'h4) ? 4'h0 : sDiv + 4'h1;
		if (hDiv == 4'h2)
			highClock <= ~highClock;
		if (sDiv == 4'h4)
			subClock <= ~subClock;
	end

	task automatic check_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic check_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
		compares++;
		if ($isunknown(g) || g < 32'(lo) || g > 32'(hi))
		begin
			err_total++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0h", nm, lo, hi, g);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
		@(posedge clock);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge clock);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		check_eq("bresp", 32'(er), 32'(bresp));
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge clock);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		rready <= 1'b0;
		d = rdata;
		check_eq("rresp", 32'((a > `PTMR_OFF_STATUS) ? `PTMR_RESP_SLVERR : `PTMR_RESP_OKAY),
			32'(rresp));
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		axi_rd(a, d);
		check_eq(nm, e, d);
	endtask
	// high byte kept whole so stray upper bits show up in the value
	task automatic rd_cnt(output logic [31:0] c);
		logic [31:0] lo, hi;
		axi_rd(`PTMR_OFF_CNTLO, lo);
		axi_rd(`PTMR_OFF_CNTHI, hi);
		c = (hi << 8) | lo;
	endtask
	task automatic cfg(input logic [7:0] cb, input logic [9:0] ca, input logic [9:0] cp);
		axi_wr(`PTMR_OFF_CTRLA, 8'h00);
		axi_wr(`PTMR_OFF_CTRLB, cb);
		axi_wr(`PTMR_OFF_CMPALO, ca[7:0]);
		axi_wr(`PTMR_OFF_CMPAHI, {6'h0, ca[9:8]});
		axi_wr(`PTMR_OFF_PERLO, cp[7:0]);
		axi_wr(`PTMR_OFF_PERHI, {6'h0, cp[9:8]});
	endtask
	// off, on, run, then pause so the count can be read at rest
	task automatic run_for(input logic [2:0] ck, input int cyc, output logic [31:0] c);
		axi_wr(`PTMR_OFF_CTRLA, 8'h00);
		axi_wr(`PTMR_OFF_CTRLA, {1'b0, ck, 4'h8});
		repeat (cyc) @(posedge clock);
		axi_wr(`PTMR_OFF_CTRLA, {1'b1, ck, 4'h8});
		rd_cnt(c);
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		#(40000 * 8);
		err_total++;
		summarize;
	end

	initial
	begin
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		for (int i = 0; i <= 8; i++)
			rd_chk(8'(4 * i), 32'h0, "reset value");
		axi_wr(`PTMR_OFF_CMPAHI, 8'hFF);
		rd_chk(`PTMR_OFF_CMPAHI, 32'h3, "compare a high");
		axi_wr(`PTMR_OFF_PERHI, 8'hFF);
		rd_chk(`PTMR_OFF_PERHI, 32'h3, "period high");
		axi_wr(`PTMR_OFF_PERLO, 8'hA5);
		rd_chk(`PTMR_OFF_PERLO, 32'hA5, "period low");
		axi_wr(`PTMR_OFF_CNTLO, 8'h55);
		rd_chk(`PTMR_OFF_CNTLO, 32'h0, "count write");
		axi_wr(`PTMR_OFF_CTRLA, 8'h07);
		rd_chk(`PTMR_OFF_CTRLA, 32'h0, "control a unused bits");
		axi_wr(8'h24, 8'h00, `PTMR_RESP_SLVERR);
		rd_chk(8'h24, 32'h0, "unmapped read");
		cfg(8'hC0, 10'h0, 10'h0);
		run_for(3'h1, 100, w);
		repeat (20) @(posedge clock);
		rd_cnt(v);
		check_eq("paused count", w, v);
		axi_wr(`PTMR_OFF_CTRLA, 8'h18);
		repeat (20) @(posedge clock);
		axi_wr(`PTMR_OFF_CTRLA, 8'h98);
		rd_cnt(v);
		check_rng("resumed count", int'(w) + 20, int'(w) + 30, v);
		w = v;
		axi_wr(`PTMR_OFF_CTRLA, 8'h10);
		repeat (20) @(posedge clock);
		rd_cnt(v);
		check_eq("off count", w, v);
		axi_wr(`PTMR_OFF_CTRLA, 8'h98);
		rd_cnt(v);
		check_eq("on clears", 32'h0, v);
		for (int i = 0; i < 6; i++)
		begin
			run_for(3'(i), 800, v);
			check_rng("clock select", 800 / CPC[i] - 1, 800 / CPC[i] + 2, v);
		end
		for (int i = 6; i < 8; i++)
		begin
			axi_wr(`PTMR_OFF_CTRLA, 8'h00);
			axi_wr(`PTMR_OFF_CTRLA, {1'b0, 3'(i), 4'h8});
			u_ptmr_pin_model.pulse(5);
			rd_cnt(v);
			check_eq("pin edges", 32'd5, v);
		end
		cfg(8'hC0, 10'h0, 10'h200);
		run_for(3'h1, 600, v);
		check_rng("period bit 9", 88, 96, v);
		for (int i = 0; i < 3; i++)
		begin
			cfg(SCB[i], 10'(SA[i]), 10'(SP[i]));
			axi_wr(`PTMR_OFF_STATUS, 8'h03);
			axi_wr(`PTMR_OFF_CTRLA, 8'h18);
			w = 32'h0;
			repeat (16)
			begin
				axi_rd(`PTMR_OFF_CNTLO, v);
				w = (v > w) ? v : w;
			end
			check_rng("clear max", SLO[i], SHI[i], w);
			rd_chk(`PTMR_OFF_STATUS, 32'(SFL[i]), "match flags");
		end
		for (int i = 0; i < 10; i++)
		begin
			cfg(PT[i][9:2], 10'd200, 10'h0);
			axi_wr(`PTMR_OFF_CTRLA, 8'h18);
			repeat (3) @(posedge clock);
			check_eq("pin initial", 32'(PT[i][1]), 32'(pinLevel));
			repeat (300) @(posedge clock);
			check_eq("pin after match", 32'(PT[i][0]), 32'(pinLevel));
		end
		for (int i = 0; i < 5; i++)
		begin
			cfg(DCB[i], 10'(DA[i]), 10'd4);
			axi_wr(`PTMR_OFF_CTRLA, 8'h18);
			repeat (8) @(posedge clock);
			n = 32'h0;
			repeat (40)
			begin
				@(posedge clock);
				n = n + 32'(pinLevel);
			end
			check_eq("duty", 32'(DH[i]), n);
		end
		cfg(8'hB8, 10'd10, 10'h0);
		axi_wr(`PTMR_OFF_STATUS, 8'h03);
		axi_wr(`PTMR_OFF_CTRLA, 8'h18);
		repeat (3) @(posedge clock);
		check_eq("pulse active", 32'h1, 32'(pinLevel));
		repeat (30) @(posedge clock);
		rd_chk(`PTMR_OFF_CTRLA, 32'h10, "pulse stops");
		check_eq("pulse ended", 32'h0, 32'(pinLevel));
		rd_chk(`PTMR_OFF_STATUS, 32'h1, "pulse flags");
		axi_wr(`PTMR_OFF_STATUS, 8'h01);
		rd_chk(`PTMR_OFF_STATUS, 32'h0, "flag clear");
		u_ptmr_pin_model.pulse(1);
		repeat (20) @(posedge clock);
		rd_chk(`PTMR_OFF_STATUS, 32'h1, "pin trigger");
		rd_chk(`PTMR_OFF_CTRLA, 32'h10, "pin pulse stops");
		cfg(8'hC0, 10'h0, 10'h0);
		check_eq("pin enable", 32'h0, 32'(timerOutputEn));
		summarize;
	end
endmodule
